// file: accl_map.vh
// Register offsets, field positions and reset values of the channel bank.
`ifndef ACCL_MAP_VH
`define ACCL_MAP_VH

// Per-input settings, one byte-wide register per input, step 0x01.
`define ACCL_CFG_BASE 8'h30
// Limit arrays, one 12-bit register per input, step 0x02.
`define ACCL_UPPER_BASE 8'h40
`define ACCL_UPPER_LAST 8'h5E
`define ACCL_LOWER_BASE 8'h60
`define ACCL_DEADBAND_BASE 8'h80
`define ACCL_ARRAY_STEP 8'h02

// Block-level registers.
`define ACCL_CTRL 8'hE0
`define ACCL_HI_STATUS 8'hE2
`define ACCL_LO_STATUS 8'hE4
`define ACCL_HI_MASK 8'hE6
`define ACCL_LO_MASK 8'hE8
`define ACCL_HI_LIVE 8'hEA
`define ACCL_LO_LIVE 8'hEC

// Settings register fields.
`define ACCL_CFG_CHECK_BIT 7
`define ACCL_CFG_HIGHZ_BIT 3
`define ACCL_CFG_RATIO_MSB 1
`define ACCL_CFG_RATIO_LSB 0
`define ACCL_CFG_WMASK 8'h8B

// Control register fields.
`define ACCL_CTRL_ADVANCED_BIT 0

// Reset values.
`define ACCL_CFG_RESET 8'h08
`define ACCL_UPPER_RESET 12'h7FF
`define ACCL_LOWER_RESET 12'h000
`define ACCL_DEADBAND_RESET 12'h010
`define ACCL_CTRL_RESET 16'h0000

// Averaging ratio codes.
`define ACCL_RATIO_1 2'h0
`define ACCL_RATIO_4 2'h1
`define ACCL_RATIO_16 2'h2
`define ACCL_RATIO_64 2'h3

`endif

// file: accl_detect.v
// Hysteresis threshold detector for one analog input.
`default_nettype none
module accl_detect #(
	parameter LIM_W = 12
) (
	input wire clk,
	input wire rst_n,
	input wire check_enable,
	input wire sample_valid,
	input wire [LIM_W-1:0] sample_top,
	input wire [LIM_W-1:0] upper,
	input wire [LIM_W-1:0] lower,
	input wire [LIM_W-1:0] deadband,
	output reg high_alert_flag,
	output reg low_alert_flag,
	output reg high_set,
	output reg low_set
);
	// Sums are one bit wider so that a large deadband cannot wrap around.
	wire [LIM_W:0] sample_plus_band;
	wire [LIM_W:0] lower_plus_band;
	wire above_upper;
	wire below_release_hi;
	wire below_lower;
	wire above_release_lo;

	assign sample_plus_band = {1'b0, sample_top} + {1'b0, deadband};
	assign lower_plus_band = {1'b0, lower} + {1'b0, deadband};
	assign above_upper = sample_top > upper;
	assign below_release_hi = sample_plus_band < {1'b0, upper};
	assign below_lower = sample_top < lower;
	assign above_release_lo = {1'b0, sample_top} > lower_plus_band;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_alert_flag <= 1'b0;
			low_alert_flag <= 1'b0;
			high_set <= 1'b0;
			low_set <= 1'b0;
		end else begin
			high_set <= 1'b0;
			low_set <= 1'b0;
			if (!check_enable) begin
				high_alert_flag <= 1'b0;
				low_alert_flag <= 1'b0;
			end else if (sample_valid) begin
				if (!high_alert_flag && above_upper) begin
					high_alert_flag <= 1'b1;
					high_set <= 1'b1;
				end else if (high_alert_flag && below_release_hi) begin
					high_alert_flag <= 1'b0;
				end
				if (!low_alert_flag && below_lower) begin
					low_alert_flag <= 1'b1;
					low_set <= 1'b1;
				end else if (low_alert_flag && above_release_lo) begin
					low_alert_flag <= 1'b0;
				end
			end
		end
	end
endmodule // accl_detect
`default_nettype wire

// file: accl_limits.v
// Per-input settings and limit register bank with alert detection.
// Notes on behaviour
// - In standard mode input zero's high-impedance bit drives all inputs.
// - In advanced mode each input takes its own high-impedance bit.
// - A high-impedance bit of zero means off and one means on.
// - In standard mode input zero's ratio field serves all inputs.
// - In advanced mode each input averages with its own ratio field.
// - Codes 0 to 3 select ratios 1, 4, 16, 64 and 16 to 19 result bits.
// - Upper limits are compared with the top twelve result bits.
// - Lower limits are compared with the top twelve result bits.
// - Deadbands are on the same twelve-bit scale as the result top bits.
// - Limit arrays start at 0x40, 0x60 and 0x80 with a step of two.
// - Upper limits reset to 0x7FF.
// - Lower limits reset to zero.
// - Deadbands reset to 0x10.
// - Alert flags stay low on inputs whose limit checking is off.
`default_nettype none
`include "accl_map.vh"
module accl_limits #(
	parameter NUM_IN = 16,
	parameter RESULT_W = 16,
	parameter LIM_W = 12
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire result_valid,
	input wire [3:0] result_channel,
	input wire [RESULT_W-1:0] result_data,
	input wire [3:0] conv_channel,
	output reg [NUM_IN-1:0] input_highz_enable,
	output reg [2*NUM_IN-1:0] averaging_ratio_select,
	output reg [6:0] conv_ratio,
	output reg [4:0] conv_result_bits,
	output reg conv_highz,
	output wire [NUM_IN-1:0] high_alert_flag,
	output wire [NUM_IN-1:0] low_alert_flag,
	output wire irq
);
	// Decodes an even address inside one 16-entry limit array.
	function in_array;
		input [7:0] addr;
		input [7:0] base;
		begin
			in_array = (addr[7:5] == base[7:5]) && !addr[0];
		end
	endfunction

	function [6:0] ratio_of;
		input [1:0] code;
		begin
			case (code)
			`ACCL_RATIO_1: ratio_of = 7'h01;
			`ACCL_RATIO_4: ratio_of = 7'h04;
			`ACCL_RATIO_16: ratio_of = 7'h10;
			`ACCL_RATIO_64: ratio_of = 7'h40;
			default: ratio_of = 7'h01;
			endcase
		end
	endfunction

	function [4:0] bits_of;
		input [1:0] code;
		begin
			case (code)
			`ACCL_RATIO_1: bits_of = 5'h10;
			`ACCL_RATIO_4: bits_of = 5'h11;
			`ACCL_RATIO_16: bits_of = 5'h12;
			`ACCL_RATIO_64: bits_of = 5'h13;
			default: bits_of = 5'h10;
			endcase
		end
	endfunction

	reg [7:0] cfg_mem [0:NUM_IN-1];
	reg [LIM_W-1:0] upper_mem [0:NUM_IN-1];
	reg [LIM_W-1:0] lower_mem [0:NUM_IN-1];
	reg [LIM_W-1:0] band_mem [0:NUM_IN-1];
	reg [15:0] ctrl;
	reg [NUM_IN-1:0] hi_status;
	reg [NUM_IN-1:0] lo_status;
	reg [NUM_IN-1:0] hi_mask;
	reg [NUM_IN-1:0] lo_mask;
	reg [15:0] next_rdata;
	reg [NUM_IN-1:0] next_highz;
	reg [2*NUM_IN-1:0] next_ratio;
	reg [NUM_IN-1:0] check_enable;
	wire [NUM_IN-1:0] hi_set;
	wire [NUM_IN-1:0] lo_set;
	wire advanced;
	wire hit_cfg;
	wire hit_upper;
	wire hit_lower;
	wire hit_band;
	wire [3:0] cfg_idx;
	wire [3:0] arr_idx;
	wire rd_hi_status;
	wire rd_lo_status;
	integer i;
	integer j;
	localparam [7:0] CFG_BASE = `ACCL_CFG_BASE;

	assign advanced = ctrl[`ACCL_CTRL_ADVANCED_BIT];
	assign hit_cfg = reg_addr[7:4] == CFG_BASE[7:4];
	assign hit_upper = in_array(reg_addr, `ACCL_UPPER_BASE);
	assign hit_lower = in_array(reg_addr, `ACCL_LOWER_BASE);
	assign hit_band = in_array(reg_addr, `ACCL_DEADBAND_BASE);
	assign cfg_idx = reg_addr[3:0];
	assign arr_idx = reg_addr[4:1];
	assign rd_hi_status = reg_rd && (reg_addr == `ACCL_HI_STATUS);
	assign rd_lo_status = reg_rd && (reg_addr == `ACCL_LO_STATUS);

	// Register writes; only documented fields are stored.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < NUM_IN; i = i + 1) begin
				cfg_mem[i] <= `ACCL_CFG_RESET;
				upper_mem[i] <= `ACCL_UPPER_RESET;
				lower_mem[i] <= `ACCL_LOWER_RESET;
				band_mem[i] <= `ACCL_DEADBAND_RESET;
			end
			ctrl <= `ACCL_CTRL_RESET;
			hi_mask <= {NUM_IN{1'b0}};
			lo_mask <= {NUM_IN{1'b0}};
		end else if (reg_wr) begin
			if (hit_cfg) begin
				cfg_mem[cfg_idx] <= reg_wdata[7:0] & `ACCL_CFG_WMASK;
			end
			if (hit_upper) begin
				upper_mem[arr_idx] <= reg_wdata[LIM_W-1:0];
			end
			if (hit_lower) begin
				lower_mem[arr_idx] <= reg_wdata[LIM_W-1:0];
			end
			if (hit_band) begin
				band_mem[arr_idx] <= reg_wdata[LIM_W-1:0];
			end
			if (reg_addr == `ACCL_CTRL) begin
				ctrl <= {15'h0000, reg_wdata[`ACCL_CTRL_ADVANCED_BIT]};
			end
			if (reg_addr == `ACCL_HI_MASK) begin
				hi_mask <= reg_wdata[NUM_IN-1:0];
			end
			if (reg_addr == `ACCL_LO_MASK) begin
				lo_mask <= reg_wdata[NUM_IN-1:0];
			end
		end
	end

	// Sticky status: a read clears it, but a same-cycle event still sets.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_status <= {NUM_IN{1'b0}};
			lo_status <= {NUM_IN{1'b0}};
		end else begin
			hi_status <= (rd_hi_status ? {NUM_IN{1'b0}} : hi_status) | hi_set;
			lo_status <= (rd_lo_status ? {NUM_IN{1'b0}} : lo_status) | lo_set;
		end
	end

	assign irq = |(hi_status & hi_mask) | |(lo_status & lo_mask);

	// Read mux; unmapped and odd array addresses return zero.
	always @* begin
		next_rdata = 16'h0000;
		if (hit_cfg) begin
			next_rdata = {8'h00, cfg_mem[cfg_idx]};
		end else if (hit_upper) begin
			next_rdata = {4'h0, upper_mem[arr_idx]};
		end else if (hit_lower) begin
			next_rdata = {4'h0, lower_mem[arr_idx]};
		end else if (hit_band) begin
			next_rdata = {4'h0, band_mem[arr_idx]};
		end else begin
			case (reg_addr)
			`ACCL_CTRL: next_rdata = ctrl;
			`ACCL_HI_STATUS: next_rdata = hi_status;
			`ACCL_LO_STATUS: next_rdata = lo_status;
			`ACCL_HI_MASK: next_rdata = hi_mask;
			`ACCL_LO_MASK: next_rdata = lo_mask;
			`ACCL_HI_LIVE: next_rdata = high_alert_flag;
			`ACCL_LO_LIVE: next_rdata = low_alert_flag;
			default: next_rdata = 16'h0000;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Scope of each setting follows the sequencer mode.
	always @* begin
		for (j = 0; j < NUM_IN; j = j + 1) begin
			if (advanced) begin
				next_highz[j] = cfg_mem[j][`ACCL_CFG_HIGHZ_BIT];
				next_ratio[2*j +: 2] = cfg_mem[j][1:0];
				check_enable[j] = cfg_mem[j][`ACCL_CFG_CHECK_BIT];
			end else begin
				next_highz[j] = cfg_mem[0][`ACCL_CFG_HIGHZ_BIT];
				next_ratio[2*j +: 2] = cfg_mem[0][1:0];
				check_enable[j] = cfg_mem[0][`ACCL_CFG_CHECK_BIT];
			end
		end
	end

	// Outputs are registered, so mode changes show one cycle later.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			input_highz_enable <= {NUM_IN{1'b0}};
			averaging_ratio_select <= {2*NUM_IN{1'b0}};
			conv_ratio <= 7'h01;
			conv_result_bits <= 5'h10;
			conv_highz <= 1'b0;
		end else begin
			input_highz_enable <= next_highz;
			averaging_ratio_select <= next_ratio;
			conv_ratio <= ratio_of(next_ratio[2*conv_channel +: 2]);
			conv_result_bits <= bits_of(next_ratio[2*conv_channel +: 2]);
			conv_highz <= next_highz[conv_channel];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_IN; g = g + 1) begin : gen_det
			accl_detect #(
				.LIM_W(LIM_W)
			) u_det (
				.clk(clk),
				.rst_n(rst_n),
				.check_enable(check_enable[g]),
				.sample_valid(result_valid && (result_channel == g)),
				.sample_top(result_data[RESULT_W-1 -: LIM_W]),
				.upper(upper_mem[g]),
				.lower(lower_mem[g]),
				.deadband(band_mem[g]),
				.high_alert_flag(high_alert_flag[g]),
				.low_alert_flag(low_alert_flag[g]),
				.high_set(hi_set[g]),
				.low_set(lo_set[g])
			);
		end
	endgenerate
endmodule // accl_limits
`default_nettype wire

// file: accl_limits_asserts.sv
// Concurrent checks on the ports of the channel settings and limit bank.
`default_nettype none
module accl_limits_chk #(
	parameter NUM_IN = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic result_valid,
	input wire logic [3:0] result_channel,
	input wire logic [3:0] conv_channel,
	input wire logic [NUM_IN-1:0] input_highz_enable,
	input wire logic [2*NUM_IN-1:0] averaging_ratio_select,
	input wire logic [6:0] conv_ratio,
	input wire logic [4:0] conv_result_bits,
	input wire logic conv_highz,
	input wire logic [NUM_IN-1:0] high_alert_flag,
	input wire logic [NUM_IN-1:0] low_alert_flag,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ch_q;
	logic [3:0] chr_q;
	logic rv_q;
	logic [1:0] cnt;
	logic [NUM_IN-1:0] hi_q;
	logic [NUM_IN-1:0] lo_q;
	// Outputs load effective settings at the first edge after reset, so
	// relations on them are armed only two edges later.
	wire up = (cnt == 2'h2);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
			ch_q <= 4'h0;
			chr_q <= 4'h0;
			rv_q <= 1'b0;
			hi_q <= '0;
			lo_q <= '0;
		end else begin
			cnt <= up ? cnt : cnt + 2'h1;
			ch_q <= conv_channel;
			chr_q <= result_channel;
			rv_q <= result_valid;
			hi_q <= high_alert_flag;
			lo_q <= low_alert_flag;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence new_high;
		(high_alert_flag & ~hi_q) != '0;
	endsequence
	sequence new_low;
		(low_alert_flag & ~lo_q) != '0;
	endsequence
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	conv_highz_a: assert property (up |-> conv_highz == input_highz_enable[ch_q])
		else $error("selected high-z differs from per-input value");
	conv_ratio_a: assert property (up |-> conv_ratio ==
		(7'h01 << (2 * averaging_ratio_select[2*ch_q +: 2])))
		else $error("ratio does not match code");
	conv_bits_a: assert property (up |-> conv_result_bits ==
		5'h10 + averaging_ratio_select[2*ch_q +: 2])
		else $error("result width does not match code");
	high_set_a: assert property (new_high |-> rv_q &&
		(high_alert_flag & ~hi_q) == (1 << chr_q))
		else $error("high alert set without a result on that input");
	low_set_a: assert property (new_low |-> rv_q &&
		(low_alert_flag & ~lo_q) == (1 << chr_q))
		else $error("low alert set without a result on that input");
	irq_rise_a: assert property ($rose(irq) |-> $past(result_valid, 2) || $past(reg_wr))
		else $error("interrupt rose without event or mask write");
	cfg_change_a: assert property (up &&
		$changed({input_highz_enable, averaging_ratio_select}) |-> $past(reg_wr, 2))
		else $error("effective settings changed without a write");
endmodule // accl_limits_chk
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the channel settings and limit bank.
`default_nettype none
`include "accl_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic result_valid = 1'b0;
	logic [7:0] reg_addr = 8'h00, k;
	logic [15:0] reg_wdata = 16'h0000, result_data = 16'h0000;
	logic [3:0] result_channel = 4'h0, conv_channel = 4'h0;
	logic [2:0] c;
	wire [15:0] reg_rdata, high_alert_flag, low_alert_flag, input_highz_enable;
	wire [31:0] averaging_ratio_select;
	wire [6:0] conv_ratio;
	wire [4:0] conv_result_bits;
	wire conv_highz, irq;
	int err_count = 0, checks_done = 0;
	accl_limits accl_limits_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .result_valid, .result_channel, .result_data,
		.conv_channel, .input_highz_enable, .averaging_ratio_select,
		.conv_ratio, .conv_result_bits, .conv_highz, .high_alert_flag,
		.low_alert_flag, .irq);
	initial begin
		forever #50 clk = ~clk;
	end
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task res(input logic [3:0] ch, input logic [15:0] d);
		@(posedge clk);
		result_valid <= 1'b1;
		result_channel <= ch;
		result_data <= d;
		@(posedge clk);
		result_valid <= 1'b0;
		#1;
	endtask
	task settle;
		@(posedge clk);
		#1;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		settle;
		`CHK(input_highz_enable, 16'hFFFF)
		`CHK(averaging_ratio_select, 32'h00000000)
		for (k = 8'h00; k < 8'h20; k += 8'h02) begin
			rdc(`ACCL_UPPER_BASE + k, 16'h07FF);
			rdc(`ACCL_LOWER_BASE + k, 16'h0000);
			rdc(`ACCL_DEADBAND_BASE + k, 16'h0010);
			rdc(`ACCL_CFG_BASE + (k >> 1), 16'h0008);
		end
		wr(`ACCL_UPPER_LAST, 16'hFABC);
		rdc(`ACCL_UPPER_LAST, 16'h0ABC);
		wr(8'h41, 16'h0123);
		rdc(8'h41, 16'h0000);
		rdc(8'h40, 16'h07FF);
		rdc(8'h20, 16'h0000);
		wr(8'h31, 16'h00FF);
		rdc(8'h31, 16'h008B);
		@(posedge clk);
		conv_channel <= 4'h5;
		for (c = 3'h0; c < 3'h4; c++) begin
			wr(`ACCL_CFG_BASE, {14'h0000, c[1:0]});
			settle;
			`CHK(conv_ratio, 7'h01 << (2 * c))
			`CHK(conv_result_bits, 5'h10 + c)
			`CHK(averaging_ratio_select, {16{c[1:0]}})
			`CHK(input_highz_enable, 16'h0000)
			`CHK(conv_highz, 1'b0)
		end
		wr(`ACCL_CTRL, 16'h0001);
		settle;
		`CHK(input_highz_enable, 16'hFFFE)
		`CHK(averaging_ratio_select, 32'h0000000F)
		rdc(`ACCL_CTRL, 16'h0001);
		@(posedge clk);
		conv_channel <= 4'h1;
		settle;
		`CHK(conv_highz, 1'b1)
		`CHK(conv_ratio, 7'h40)
		wr(8'h42, 16'h0100);
		wr(8'h62, 16'h0080);
		wr(`ACCL_HI_MASK, 16'hFFFF);
		wr(`ACCL_LO_MASK, 16'hFFFF);
		res(4'h1, 16'h1010);
		`CHK(high_alert_flag, 16'h0002)
		settle;
		`CHK(irq, 1'b1)
		rdc(`ACCL_HI_STATUS, 16'h0002);
		`CHK(irq, 1'b0)
		res(4'h1, 16'h0F80);
		`CHK(high_alert_flag, 16'h0002)
		rdc(`ACCL_HI_LIVE, 16'h0002);
		res(4'h1, 16'h0EF0);
		`CHK(high_alert_flag, 16'h0000)
		res(4'h1, 16'h07F0);
		`CHK(low_alert_flag, 16'h0002)
		rdc(`ACCL_LO_LIVE, 16'h0002);
		res(4'h1, 16'h08F0);
		`CHK(low_alert_flag, 16'h0002)
		res(4'h1, 16'h0910);
		`CHK(low_alert_flag, 16'h0000)
		res(4'h2, 16'hFFF0);
		`CHK(high_alert_flag, 16'h0000)
		rdc(`ACCL_LO_STATUS, 16'h0002);
		rdc(`ACCL_LO_STATUS, 16'h0000);
		`CHK(irq, 1'b0)
		wr(`ACCL_CFG_BASE, 16'h0000);
		wr(`ACCL_CFG_BASE + 8'h01, 16'h0088);
		settle;
		`CHK(averaging_ratio_select, 32'h00000000)
		`CHK(input_highz_enable, 16'hFFFE)
		print_verdict;
	end
endmodule // tb_top
bind accl_limits accl_limits_chk #(.NUM_IN(NUM_IN)) accl_limits_chk_i (.clk,
	.rst_n, .reg_wr, .reg_rd, .reg_rdata, .result_valid, .result_channel,
	.conv_channel, .input_highz_enable, .averaging_ratio_select, .conv_ratio,
	.conv_result_bits, .conv_highz, .high_alert_flag, .low_alert_flag, .irq);
`default_nettype wire
